// File: src/rtc_counters.sv
`timescale 1ns/100ps
module rtc_counters
  import rtc_pkg::*;
#(
  parameter int DIV_COUNT = OSC_HZ,
  parameter int STOP_LIM = STOP_CYCLES
) (
  input wire logic sys_clk,             // System clock, 125 MHz
  input wire logic rst_n,               // Asynchronous reset, active low
  input wire logic osc_clk,             // Crystal clock
  input wire logic access_active,       // Host access window from the serial slave
  input wire logic [7:0] reg_addr,      // Register address
  input wire logic reg_wr_en,           // Write strobe, one cycle
  input wire logic [7:0] reg_wr_data,   // Write data
  output logic [7:0] reg_rd_data,       // Read data, one cycle after address
  input wire logic hour_format_select,  // 1 selects twelve-hour mode
  output logic oscillator_stop_flag     // Clock integrity not guaranteed
);
  logic sec_tick;
  logic osc_running;
  logic pending;
  logic [6:0] seconds;
  logic [6:0] minutes;
  logic [5:0] hours;
  logic [5:0] days;
  logic [2:0] wday;
  logic [4:0] month;
  logic [7:0] year;

  rtc_osc_if link ();

  rtc_osc_div #(.DIV_COUNT(DIV_COUNT)) u_div (
    .osc_clk(osc_clk),
    .rst_n(rst_n),
    .link(link)
  );

  rtc_osc_watch #(.STOP_LIM(STOP_LIM)) u_watch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link(link),
    .sec_tick(sec_tick),
    .osc_running(osc_running)
  );

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Write decode
  wire wr_sec = reg_wr_en && reg_addr == SEC_ADDR;
  wire wr_min = reg_wr_en && reg_addr == MIN_ADDR;
  wire wr_hour = reg_wr_en && reg_addr == HOUR_ADDR;
  wire wr_day = reg_wr_en && reg_addr == DAY_ADDR;
  wire wr_wday = reg_wr_en && reg_addr == WDAY_ADDR;
  wire wr_month = reg_wr_en && reg_addr == MONTH_ADDR;
  wire wr_year = reg_wr_en && reg_addr == YEAR_ADDR;

  // A tick during the window is held; a second one in the same window is lost,
  // which is why the host must keep each access under one second
  wire inc = !access_active && (sec_tick || pending);
  wire next_pending = access_active && (pending || sec_tick);

  // Carry chain
  wire sec_wrap = (seconds == MINSEC_MAX);
  wire min_wrap = (minutes == MINSEC_MAX);
  wire h12_pm = hours[MERIDIEM_BIT];
  wire [4:0] h12 = hours[4:0];
  wire hour_wrap = hour_format_select ? (h12_pm && h12 == HOUR12_LAST)
                                      : (hours == HOUR24_MAX);
  wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                      : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                         year[3:0] == 4'h8);
  wire short_month = month == MONTH_APR || month == MONTH_JUN ||
                     month == MONTH_SEP || month == MONTH_NOV;
  wire [5:0] month_days = (month == MONTH_FEB) ? (leap ? DAY_29 : DAY_28) :
                          short_month ? DAY_30 : DAY_31;
  wire day_wrap = (days == month_days);
  wire month_wrap = (month == MONTH_DEC);

  wire inc_min = inc && sec_wrap;
  wire inc_hour = inc_min && min_wrap;
  wire inc_day = inc_hour && hour_wrap;
  wire inc_month = inc_day && day_wrap;
  wire inc_year = inc_month && month_wrap;

  wire [7:0] sec_inc = bcd_inc({1'b0, seconds});
  wire [7:0] min_inc = bcd_inc({1'b0, minutes});
  wire [7:0] h12_inc = bcd_inc({3'h0, h12});
  wire [7:0] h24_inc = bcd_inc({2'h0, hours});
  wire [7:0] day_inc = bcd_inc({2'h0, days});
  wire [7:0] month_inc = bcd_inc({3'h0, month});
  wire [6:0] sec_up = sec_wrap ? 7'h00 : sec_inc[6:0];
  wire [6:0] min_up = min_wrap ? 7'h00 : min_inc[6:0];
  // Twelve-hour order is 12, 01 .. 11; meridiem flips on the 11 to 12 step
  wire [4:0] h12_step = (h12 == HOUR12_TOP) ? HOUR12_FIRST :
                        h12_inc[4:0];
  wire [5:0] h12_up = {(h12 == HOUR12_LAST) ? ~h12_pm : h12_pm, h12_step};
  wire [5:0] h24_up = hour_wrap ? 6'h00 : h24_inc[5:0];
  wire [5:0] hour_up = hour_format_select ? h12_up : h24_up;
  wire [5:0] day_up = day_wrap ? DAY_FIRST : day_inc[5:0];
  wire [2:0] wday_up = (wday == WDAY_MAX) ? 3'h0 : wday + 3'h1;
  wire [4:0] month_up = month_wrap ? 5'h01 : month_inc[4:0];
  wire [7:0] year_up = (year == YEAR_MAX) ? 8'h00 : bcd_inc(year);

  // Host writes take precedence over a carry landing in the same cycle
  wire [6:0] next_sec = wr_sec ? reg_wr_data[6:0] : inc ? sec_up : seconds;
  wire [6:0] next_min = wr_min ? reg_wr_data[6:0] : inc_min ? min_up : minutes;
  wire [5:0] next_hour = wr_hour ? reg_wr_data[5:0] : inc_hour ? hour_up : hours;
  wire [5:0] next_day = wr_day ? reg_wr_data[5:0] : inc_day ? day_up : days;
  wire [2:0] next_wday = wr_wday ? reg_wr_data[2:0] : inc_day ? wday_up : wday;
  wire [4:0] next_month = wr_month ? reg_wr_data[4:0] : inc_month ? month_up : month;
  wire [7:0] next_year = wr_year ? reg_wr_data : inc_year ? year_up : year;

  // Stop sets and wins over a clearing write; a clear only lands while running
  wire stop_clear = wr_sec && !reg_wr_data[STOP_FLAG_BIT] && osc_running;
  wire next_stop_flag = !osc_running || (oscillator_stop_flag && !stop_clear);

  // Unused bits read as zero; the seconds word carries the stop flag on top
  wire [7:0] rd_sec = {oscillator_stop_flag, seconds};
  wire [7:0] rd_min = {1'b0, minutes};
  wire [7:0] rd_hour = {2'h0, hours};
  wire [7:0] rd_day = {2'h0, days};
  wire [7:0] rd_wday = {5'h00, wday};
  wire [7:0] rd_month = {3'h0, month};

  wire [7:0] next_rd_data =
    (reg_addr == SEC_ADDR) ? rd_sec :
    (reg_addr == MIN_ADDR) ? rd_min :
    (reg_addr == HOUR_ADDR) ? rd_hour :
    (reg_addr == DAY_ADDR) ? rd_day :
    (reg_addr == WDAY_ADDR) ? rd_wday :
    (reg_addr == MONTH_ADDR) ? rd_month :
    (reg_addr == YEAR_ADDR) ? year : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_stop_flag <= STOP_FLAG_RST;
      pending <= 1'b0;
    end else begin
      oscillator_stop_flag <= next_stop_flag;
      pending <= next_pending;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seconds <= SEC_RST;
      minutes <= MIN_RST;
      hours <= HOUR_RST;
      days <= DAY_RST;
    end else begin
      seconds <= next_sec;
      minutes <= next_min;
      hours <= next_hour;
      days <= next_day;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wday <= WDAY_RST;
      month <= MONTH_RST;
      year <= YEAR_RST;
      reg_rd_data <= 8'h00;
    end else begin
      wday <= next_wday;
      month <= next_month;
      year <= next_year;
      reg_rd_data <= next_rd_data;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence tick_in_window;
    access_active && sec_tick;
  endsequence
  sequence window_closes;
    !access_active;
  endsequence
  sequence quiet_access;
    access_active && !reg_wr_en;
  endsequence
  sequence stopped_clear;
    !osc_running && wr_sec && !reg_wr_data[STOP_FLAG_BIT];
  endsequence
  sequence running_clear;
    osc_running && wr_sec && !reg_wr_data[STOP_FLAG_BIT];
  endsequence
  sequence last_second;
    inc && sec_wrap && !wr_sec && !wr_min;
  endsequence

  sec_bcd_a: assert property (!wr_sec |-> seconds <= MINSEC_MAX && seconds[3:0] <= 4'h9)
    else $error("seconds left BCD range");
  stop_sticky_a: assert property (oscillator_stop_flag && !wr_sec |=> oscillator_stop_flag)
    else $error("stop flag cleared without write");
  stop_hold_a: assert property (stopped_clear |=> oscillator_stop_flag)
    else $error("stop flag cleared while oscillator stopped");
  min_roll_a: assert property (inc_min && minutes == MINSEC_MAX && !wr_min
    |=> minutes == 7'h00)
    else $error("minutes failed to roll over");
  meridiem_flip_a: assert property (inc_hour && hour_format_select && !wr_hour
    && h12 == HOUR12_LAST |=> h12 == HOUR12_TOP && h12_pm != $past(h12_pm))
    else $error("meridiem did not change at twelve");
  hour24_roll_a: assert property (inc_hour && !hour_format_select && !wr_hour
    && hours == HOUR24_MAX |=> hours == 6'h00 && days != $past(days))
    else $error("day did not advance at midnight");
  leap_feb_a: assert property (inc_day && !wr_day && month == MONTH_FEB
    && days == DAY_28 |=> days == (leap ? DAY_29 : DAY_FIRST))
    else $error("February length wrong for year");
  wday_range_a: assert property (!wr_wday |-> wday <= WDAY_MAX)
    else $error("weekday out of range");
  month_roll_a: assert property (inc_month && !wr_month && !wr_year
    && month == MONTH_DEC |=> month == 5'h01 && year != $past(year))
    else $error("year did not advance after December");
  year_bcd_a: assert property (!wr_year |-> year[3:0] <= 4'h9 && year[7:4] <= 4'h9)
    else $error("year left BCD range");
  freeze_a: assert property (quiet_access |=> $stable(seconds) && $stable(minutes)
    && $stable(hours) && $stable(days) && $stable(month) && $stable(year))
    else $error("counter moved during access");
  held_tick_a: assert property (tick_in_window ##1 window_closes
    |-> inc ##1 !pending)
    else $error("held tick not applied after access");

  // Flag, held-tick, seconds-step and read-back checks
  stop_set_a: assert property (!osc_running |=> oscillator_stop_flag)
    else $error("stop flag not set while oscillator stopped");
  stop_clear_a: assert property (running_clear |=> !oscillator_stop_flag)
    else $error("stop flag not cleared by write");
  pend_set_a: assert property (tick_in_window |=> pending)
    else $error("tick in access window not held");
  pend_clear_a: assert property (window_closes |=> !pending)
    else $error("held tick kept after access");
  idle_hold_a: assert property (!inc && !wr_sec |=> $stable(seconds))
    else $error("seconds moved without tick");
  sec_step_a: assert property (inc && !wr_sec |=> seconds != $past(seconds))
    else $error("seconds did not advance on tick");
  rd_sec_a: assert property (reg_addr == SEC_ADDR
    |=> reg_rd_data == $past(rd_sec))
    else $error("seconds word read back wrong");
  rd_min_a: assert property (reg_addr == MIN_ADDR
    |=> reg_rd_data == $past(rd_min))
    else $error("minutes word read back wrong");
  rd_hour_a: assert property (reg_addr == HOUR_ADDR
    |=> reg_rd_data == $past(rd_hour))
    else $error("hours word read back wrong");
  rd_day_a: assert property (reg_addr == DAY_ADDR
    |=> reg_rd_data == $past(rd_day))
    else $error("day word read back wrong");
  rd_month_a: assert property (reg_addr == MONTH_ADDR
    |=> reg_rd_data == $past(rd_month))
    else $error("month word read back wrong");
  rd_year_a: assert property (reg_addr == YEAR_ADDR
    |=> reg_rd_data == $past(year))
    else $error("years word read back wrong");

  // Calendar checks
  sec_roll_a: assert property (last_second
    |=> seconds == 7'h00 && minutes != $past(minutes))
    else $error("seconds did not roll into minutes");
  min_bcd_a: assert property (!wr_min
    |-> minutes <= MINSEC_MAX && minutes[3:0] <= 4'h9)
    else $error("minutes left BCD range");
  day_range_a: assert property (!wr_day
    |-> days >= DAY_FIRST && days <= DAY_31 && days[3:0] <= 4'h9)
    else $error("day of month left range");
  day_roll_a: assert property (inc_day && !wr_day && day_wrap |=> days == DAY_FIRST)
    else $error("day of month did not wrap");
  month_end_a: assert property (inc_day && !wr_day && !wr_month && short_month
    && days == DAY_30 |=> days == DAY_FIRST && month != $past(month))
    else $error("thirty-day month did not end");
  feb_leap_a: assert property (inc_day && !wr_day && leap && month == MONTH_FEB
    && days == DAY_29 |=> days == DAY_FIRST)
    else $error("leap February did not end on 29");
  wday_roll_a: assert property (inc_day && !wr_wday && wday == WDAY_MAX
    |=> wday == 3'h0)
    else $error("weekday did not wrap");
  month_range_a: assert property (!wr_month
    |-> month >= 5'h01 && month <= MONTH_DEC && month[3:0] <= 4'h9)
    else $error("month left range");
  year_roll_a: assert property (inc_year && !wr_year && year == YEAR_MAX
    |=> year == 8'h00)
    else $error("year did not wrap after 99");
  hour12_top_a: assert property (inc_hour && hour_format_select && !wr_hour
    && h12 == HOUR12_TOP |=> h12 == HOUR12_FIRST && h12_pm == $past(h12_pm))
    else $error("twelve did not step to one");
endmodule

// File: pkg/rtc_pkg.sv
package rtc_pkg;
  // Register locations as seen by the serial slave
  localparam logic [7:0] SEC_ADDR = 8'h03;
  localparam logic [7:0] MIN_ADDR = 8'h04;
  localparam logic [7:0] HOUR_ADDR = 8'h05;
  localparam logic [7:0] DAY_ADDR = 8'h06;
  localparam logic [7:0] WDAY_ADDR = 8'h07;
  localparam logic [7:0] MONTH_ADDR = 8'h08;
  localparam logic [7:0] YEAR_ADDR = 8'h09;
  localparam int STOP_FLAG_BIT = 7;
  localparam int MERIDIEM_BIT = 5;

  // Values after reset
  localparam logic STOP_FLAG_RST = 1'b1;
  localparam logic [6:0] SEC_RST = 7'h00;
  localparam logic [6:0] MIN_RST = 7'h00;
  localparam logic [5:0] HOUR_RST = 6'h00;
  localparam logic [5:0] DAY_RST = 6'h01;
  localparam logic [2:0] WDAY_RST = 3'h0;
  localparam logic [4:0] MONTH_RST = 5'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;

  // BCD limits
  localparam logic [6:0] MINSEC_MAX = 7'h59;
  localparam logic [5:0] HOUR24_MAX = 6'h23;
  localparam logic [4:0] HOUR12_LAST = 5'h11;
  localparam logic [4:0] HOUR12_TOP = 5'h12;
  localparam logic [4:0] HOUR12_FIRST = 5'h01;
  localparam logic [5:0] DAY_FIRST = 6'h01;
  localparam logic [5:0] DAY_28 = 6'h28;
  localparam logic [5:0] DAY_29 = 6'h29;
  localparam logic [5:0] DAY_30 = 6'h30;
  localparam logic [5:0] DAY_31 = 6'h31;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [4:0] MONTH_FEB = 5'h02;
  localparam logic [4:0] MONTH_APR = 5'h04;
  localparam logic [4:0] MONTH_JUN = 5'h06;
  localparam logic [4:0] MONTH_SEP = 5'h09;
  localparam logic [4:0] MONTH_NOV = 5'h11;
  localparam logic [4:0] MONTH_DEC = 5'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;

  // Crystal domain
  localparam int OSC_HZ = 32768;
  localparam int DIV_CNT_W = 15;
  localparam int BEAT_CNT_W = 3;

  // Oscillator-stop detection in the system domain
  localparam int CLK_MHZ = 125;
  localparam int STOP_TIME_US = 2000;
  localparam int STOP_CYCLES = STOP_TIME_US * CLK_MHZ;
  localparam int STOP_CNT_W = 18;
endpackage

// File: pkg/rtc_osc_if.sv
`timescale 1ns/100ps
interface rtc_osc_if;
  logic sec_toggle;
  logic beat_toggle;
  modport src (output sec_toggle, output beat_toggle);
  modport dst (input sec_toggle, input beat_toggle);
endinterface

// File: src/rtc_osc_div.sv
`timescale 1ns/100ps
module rtc_osc_div
  import rtc_pkg::*;
#(
  parameter int DIV_COUNT = OSC_HZ
) (
  input wire logic osc_clk,  // Crystal clock, crystal_input_pin side
  input wire logic rst_n,    // Asynchronous reset, active low
  rtc_osc_if.src link        // Toggles toward the system domain
);
  logic [1:0] rst_sync;
  logic [DIV_CNT_W-1:0] div_cnt;
  logic [BEAT_CNT_W-1:0] beat_cnt;
  logic sec_toggle;
  logic beat_toggle;
  localparam logic [DIV_CNT_W-1:0] DIV_LAST = DIV_CNT_W'(DIV_COUNT - 1);
  wire div_wrap = (div_cnt == DIV_LAST);
  wire beat_wrap = &beat_cnt;

  // Release of reset is re-timed to the crystal so the divider starts cleanly
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      beat_cnt <= '0;
      sec_toggle <= 1'b0;
      beat_toggle <= 1'b0;
    end else if (rst_sync[1]) begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
      beat_cnt <= beat_cnt + 1'b1;
      if (div_wrap) sec_toggle <= ~sec_toggle;
      // Heartbeat is slow enough for the system clock to see every edge
      if (beat_wrap) beat_toggle <= ~beat_toggle;
    end
  end

  assign link.sec_toggle = sec_toggle;
  assign link.beat_toggle = beat_toggle;

  div_period_a: assert property (@(posedge osc_clk) disable iff (!rst_n)
    div_wrap && rst_sync[1] |=> div_cnt == '0 && $changed(sec_toggle))
    else $error("second toggle did not follow divider wrap");
endmodule

// File: src/rtc_osc_watch.sv
`timescale 1ns/100ps
module rtc_osc_watch
  import rtc_pkg::*;
#(
  parameter int STOP_LIM = STOP_CYCLES
) (
  input wire logic sys_clk,  // System clock
  input wire logic rst_n,    // Asynchronous reset, active low
  rtc_osc_if.dst link,       // Toggles from the crystal domain
  output logic sec_tick,     // One-cycle pulse per second
  output logic osc_running   // Crystal seen alive recently
);
  localparam logic [STOP_CNT_W-1:0] LIM = STOP_CNT_W'(STOP_LIM);
  logic [2:0] sec_sync;
  logic [2:0] beat_sync;
  logic [STOP_CNT_W-1:0] stop_cnt;
  wire beat_edge = beat_sync[2] ^ beat_sync[1];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_sync <= 3'h0;
      beat_sync <= 3'h0;
    end else begin
      sec_sync <= {sec_sync[1:0], link.sec_toggle};
      beat_sync <= {beat_sync[1:0], link.beat_toggle};
    end
  end

  // Starts saturated: the crystal counts as stopped until it shows activity
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) stop_cnt <= LIM;
    else if (beat_edge) stop_cnt <= '0;
    else if (stop_cnt != LIM) stop_cnt <= stop_cnt + 1'b1;
  end

  assign sec_tick = sec_sync[2] ^ sec_sync[1];
  assign osc_running = (stop_cnt != LIM);

  stop_detect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    osc_running && !beat_edge && stop_cnt == LIM - 1'b1 |=> !osc_running)
    else $error("oscillator stop not flagged at timeout");
  beat_alive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    beat_edge |=> osc_running)
    else $error("oscillator activity not recognised");
endmodule

// File: tb/rtc_host_model.sv
`timescale 1ns/100ps
module rtc_host_model
  import rtc_pkg::*;
(
  input wire logic sys_clk,          // System clock
  output logic access_active,        // Access window
  output logic [7:0] reg_addr,       // Register address
  output logic reg_wr_en,            // Write strobe
  output logic [7:0] reg_wr_data,    // Write data
  input wire logic [7:0] reg_rd_data // Read data
);
  initial begin
    access_active = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
  end
  // Windows opened by set_all and get_all stay fifteen cycles, well inside one tick period
  task automatic win(input logic on);
    @(negedge sys_clk);
    access_active = on;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rd_data;
  endtask
  // Whole span in one window so a carry cannot split the fields
  task automatic set_all(input logic [7:0] v [7]);
    win(1'b1);
    for (int i = 0; i < 7; i++) wr(SEC_ADDR + 8'(i), v[i]);
    win(1'b0);
  endtask
  task automatic get_all(output logic [7:0] v [7]);
    win(1'b1);
    for (int i = 0; i < 7; i++) rd(SEC_ADDR + 8'(i), v[i]);
    win(1'b0);
  endtask
endmodule

// File: tb/test_rtc_time_calendar_counters.sv
`timescale 1ns/100ps
module test_rtc_time_calendar_counters;
  import rtc_pkg::*;
  logic sys_clk, rst_n, osc_clk, osc_on, hour_format_select;
  logic access_active, reg_wr_en, oscillator_stop_flag;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, r, m, y, d;
  logic [7:0] t [7];
  logic [7:0] e [7];
  logic [7:0] g [7];
  logic [7:0] cd [4] = '{8'h28, 8'h29, 8'h28, 8'h31};
  logic [7:0] cm [4] = '{8'h02, 8'h02, 8'h02, 8'h12};
  logic [7:0] cy [4] = '{8'h00, 8'h04, 8'h01, 8'h99};
  int n_errors, checks, seed, k;

  rtc_counters #(.DIV_COUNT(64), .STOP_LIM(200)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .osc_clk(osc_clk), .access_active(access_active),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .hour_format_select(hour_format_select),
    .oscillator_stop_flag(oscillator_stop_flag));
  rtc_host_model u_host (
    .sys_clk(sys_clk), .access_active(access_active), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Crystal halts at its current level when disabled, high or low, as a stalled oscillator would
  initial begin
    osc_clk = 1'b0;
    #1.3;
    forever #3 if (osc_on) osc_clk = ~osc_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [7:0] binc(input logic [7:0] x);
    if (x == 8'h99) return 8'h00;
    return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
  endfunction
  function automatic logic [7:0] tobcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  function automatic logic [7:0] dim(input logic [7:0] mo, input logic [7:0] yr);
    if (mo == 8'h02) return ((yr[7:4] * 10 + yr[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
    if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) return 8'h30;
    return 8'h31;
  endfunction
  function automatic int rnd(input int n);
    return int'($unsigned($random(seed)) % n);
  endfunction

  // Last second of the hour, then wait for the tick and read back
  task automatic day_case(input logic [7:0] dd, mm, yy, h, eh, input logic roll);
    logic [7:0] lim, wd;
    lim = dim(mm, yy);
    wd = 8'(rnd(7));
    t = '{8'h59, 8'h59, h, dd, wd, mm, yy};
    e = t;
    e[0] = 8'h00;
    e[1] = 8'h00;
    e[2] = eh;
    if (roll) begin
      e[4] = (wd == 8'h06) ? 8'h00 : wd + 8'h01;
      e[3] = (dd == lim) ? 8'h01 : binc(dd);
      if (dd == lim) e[5] = (mm == 8'h12) ? 8'h01 : binc(mm);
      if (dd == lim && mm == 8'h12) e[6] = binc(yy);
    end
    u_host.set_all(t);
    r = 8'h59;
    k = 0;
    while (r[6:0] !== 7'h00 && k < 200) begin
      u_host.rd(SEC_ADDR, r);
      k++;
    end
    u_host.get_all(g);
    for (int i = 0; i < 7; i++) chk(g[i], e[i]);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    n_errors = 0;
    checks = 0;
    seed = 19261;
    rst_n = 1'b0;
    osc_on = 1'b0;
    hour_format_select = 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    u_host.get_all(g);
    e = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 7; i++) chk(g[i], e[i]);
    u_host.rd(8'h0a, r);
    chk(r, 8'h00);
    for (int p = 0; p < 2; p++) begin
      u_host.wr(SEC_ADDR, 8'h00);
      repeat (5) @(negedge sys_clk);
      chk({7'h00, oscillator_stop_flag}, 8'h01);
      osc_on = 1'b1;
      repeat (40) @(negedge sys_clk);
      u_host.wr(SEC_ADDR, 8'h00);
      u_host.rd(SEC_ADDR, r);
      chk(r[7:0] & 8'h80, 8'h00);
      if (p == 0) begin
        for (int c = 0; c < 4; c++) day_case(cd[c], cm[c], cy[c], 8'h23, 8'h00, 1'b1);
        for (int c = 0; c < 12; c++) begin
          m = tobcd(1 + rnd(12));
          y = tobcd(rnd(100));
          d = (c % 2 == 1) ? dim(m, y) : tobcd(1 + rnd(28));
          day_case(d, m, y, 8'h23, 8'h00, 1'b1);
        end
        @(negedge sys_clk);
        hour_format_select = 1'b1;
        day_case(8'h10, 8'h05, 8'h20, 8'h31, 8'h12, 1'b1);
        day_case(8'h10, 8'h05, 8'h20, 8'h11, 8'h32, 1'b0);
        @(negedge sys_clk);
        hour_format_select = 1'b0;
        // Open the window right after a tick so exactly one tick lands inside it
        u_host.rd(SEC_ADDR, m);
        r = m;
        k = 0;
        while (r === m && k < 100) begin
          u_host.rd(SEC_ADDR, r);
          k++;
        end
        u_host.win(1'b1);
        u_host.wr(SEC_ADDR, 8'h10);
        repeat (50) @(negedge sys_clk);
        u_host.rd(SEC_ADDR, r);
        chk(r, 8'h10);
        u_host.win(1'b0);
        u_host.rd(SEC_ADDR, r);
        chk(r, 8'h11);
        osc_on = 1'b0;
        repeat (300) @(negedge sys_clk);
        chk({7'h00, oscillator_stop_flag}, 8'h01);
      end
    end
    wrap_up();
  end
endmodule
